// ---- hdl/dma_access.sv ----
`default_nettype none
// Function
// - Program counter is 15 bits, addressing 32K words of 16 bits.
// - Normal map: 32 registers, 64 I/O, 160 extended I/O, 4096 SRAM.
// - Legacy map: 32 registers, 64 I/O, 4000 SRAM bytes.
// - Extended I/O only reachable by load/store, not short I/O access.
// - In legacy mode extended I/O addresses belong to internal SRAM.
// - External SRAM starts right after internal SRAM, same instructions.
// - External strobes stay inactive during internal accesses.
// - External SRAM works only when its enable bit is set.
// - External byte access without wait states costs one extra cycle.
// - One, two, three wait states cost two, three, four extra cycles.
// - External stack word ops cost 3, 5, 7 or 9 extra cycles.
// - Displacement mode adds up to 63 to the pointer base.
// - Pre-decrement and post-increment update the pointer register.
// - Internal SRAM access completes in two clock cycles.
// - EEPROM is a separate 2K byte space with byte read and write.
// - EEPROM registers sit in the standard I/O space.
// - Stall four cycles after EEPROM read, two after EEPROM write.
// - EEPROM write is self-timed with a pollable status.
// - EEPROM write starts only after the arming step.
// - EEPROM address bits 10..0 used, bits 15..11 read zero.
// - Data register holds write byte, or byte fetched by a read.
// - Arm bit clears after four cycles; strobe must come within.
// - Write strobe bit clears when the self-timed write completes.
// - Read strobe fetches the addressed byte into the data register.
// - During a write, reads are blocked and address changes ignored.
module dma_access
    import dma_pkg::*;
#(
    parameter int EE_WRITE_LEN = EE_WRITE_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              legacy_mode,
    input  wire logic [PC_W-1:0]   pc_next,
    output var  logic [PC_W-1:0]   prog_addr,
    input  wire logic              req_valid,
    input  wire dma_req_t          req,
    output var  logic              req_ready,
    output var  logic              ack,
    output var  logic [7:0]        rdata,
    output var  logic [15:0]       ptr_upd,
    input  wire logic [7:0]        periph_rdata,
    output var  logic [15:0]       ext_addr,
    output var  logic [7:0]        ext_data_o,
    output var  logic              ext_data_oe,
    input  wire logic [7:0]        ext_data_i,
    output var  logic              ext_strobe_pin_a_n,
    output var  logic              ext_strobe_pin_b_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [7:0]          sram [SRAM_DEPTH];
    logic [7:0]          eemem [EE_DEPTH];
    dma_state_t          state;
    logic [CNT_W-1:0]    cnt;
    dma_region_t         lat_region;
    logic [15:0]         lat_ea;
    logic [SRAM_AW-1:0]  lat_idx;
    logic                lat_ext;
    logic [7:0]          mcu_control_reg;
    logic                ee_arm;
    logic [CNT_W-1:0]    arm_cnt;
    logic                ee_busy;
    logic [EE_TW-1:0]    ee_tcnt;
    logic [EE_AW-1:0]    eeprom_address;
    logic [7:0]          eeprom_data_byte;
    logic [EE_AW-1:0]    wr_addr;
    logic [7:0]          wr_data;

    logic                accept;
    logic                done;
    logic [15:0]         ea;
    logic [15:0]         next_ptr;
    dma_region_t         region;
    logic                ext_on;
    logic [1:0]          ws;
    logic [CNT_W-1:0]    extra;
    logic [SRAM_AW-1:0]  sidx;
    logic                wr_hit;
    logic                ee_ctrl_wr;
    logic                ee_rd_go;
    logic                ee_wr_go;
    logic                arm_set;
    logic [7:0]          own_rd;
    logic                own_hit;
    logic [15:0]         rd_ea;

    assign accept = req_valid && req_ready;
    assign done   = (state == ST_BUSY) && (cnt == '0);
    assign ws     = mcu_control_reg[MC_WS_LSB +: 2];
    // Zero-extra accesses finish at the take edge, so read the live address
    assign rd_ea  = (state == ST_IDLE) ? ea : lat_ea;

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_addr <= '0;
        end else begin
            prog_addr <= pc_next;
        end
    end

    // Address generation and decode
    always_comb begin
        case (req.mode)
            PM_DISP:   ea = req.addr + {10'h000, req.disp};
            PM_PREDEC: ea = req.addr - 16'h0001;
            default:   ea = req.addr;
        endcase
        case (req.mode)
            PM_PREDEC:  next_ptr = req.addr - 16'h0001;
            PM_POSTINC: next_ptr = req.addr + 16'h0001;
            default:    next_ptr = req.addr;
        endcase
        if (req.io_short) begin
            ea = IO_BASE + {10'h000, req.addr[5:0]};
        end
        region = dma_decode(ea, legacy_mode);
        if (legacy_mode) begin
            sidx = SRAM_AW'(ea - IO_END);
        end else begin
            sidx = SRAM_AW'(ea - XIO_END);
        end
        ext_on = (region == RG_EXT) && mcu_control_reg[MC_SRE_BIT];
    end

    // EEPROM strobes decoded from a store to the control register
    always_comb begin
        wr_hit     = accept && req.we;
        ee_ctrl_wr = wr_hit && (ea == EE_CTRL_ADDR);
        arm_set    = ee_ctrl_wr && req.wdata[EC_ARM_BIT];
        ee_rd_go   = ee_ctrl_wr && req.wdata[EC_RE_BIT] && !ee_busy;
        ee_wr_go   = ee_ctrl_wr && req.wdata[EC_WE_BIT] && ee_arm
                     && !ee_busy;
    end

    // Extra cycles beyond the two-cycle internal access
    always_comb begin
        extra = '0;
        if (ext_on && req.stack2) begin
            extra = EXT_STACK_EXTRA + CNT_W'({ws, 1'b0});
        end else if (ext_on) begin
            extra = EXT_BYTE_EXTRA + CNT_W'(ws);
        end
        if (ee_rd_go) begin
            extra = EE_RD_STALL;
        end else if (ee_wr_go) begin
            extra = EE_WR_STALL;
        end
    end

    // Readback of the registers this block owns
    always_comb begin
        own_hit = 1'b1;
        case (rd_ea)
            EE_CTRL_ADDR: own_rd = {5'h00, ee_arm, ee_busy, 1'b0};
            EE_DATA_ADDR: own_rd = eeprom_data_byte;
            EE_ADRL_ADDR: own_rd = eeprom_address[7:0];
            EE_ADRH_ADDR: own_rd = {5'h00, eeprom_address[10:8]};
            MCU_CTRL_ADDR: own_rd = mcu_control_reg;
            default: begin
                own_rd  = periph_rdata;
                own_hit = 1'b0;
            end
        endcase
    end

    // Access sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= ST_IDLE;
            cnt        <= '0;
            req_ready  <= 1'b1;
            ack        <= 1'b0;
            rdata      <= '0;
            ptr_upd    <= '0;
            lat_region <= RG_RF;
            lat_ea     <= '0;
            lat_idx    <= '0;
            lat_ext    <= 1'b0;
        end else begin
            ack <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        ptr_upd    <= next_ptr;
                        lat_region <= region;
                        lat_ea     <= ea;
                        lat_idx    <= sidx;
                        lat_ext    <= ext_on;
                        if (extra == '0) begin
                            ack <= 1'b1;
                            case (region)
                                RG_SRAM: rdata <= sram[sidx];
                                RG_EXT:  rdata <= EXT_UNDEF;
                                default: rdata <= own_rd;
                            endcase
                        end else begin
                            state     <= ST_BUSY;
                            req_ready <= 1'b0;
                            cnt       <= extra - 5'h01;
                        end
                    end
                end
                ST_BUSY: begin
                    if (cnt == '0) begin
                        state     <= ST_IDLE;
                        req_ready <= 1'b1;
                        ack       <= 1'b1;
                        case (lat_region)
                            RG_SRAM: rdata <= sram[lat_idx];
                            RG_EXT: begin
                                rdata <= lat_ext ? ext_data_i : EXT_UNDEF;
                            end
                            default: rdata <= own_rd;
                        endcase
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (wr_hit && region == RG_SRAM) begin
            sram[sidx] <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mcu_control_reg <= MCU_CTRL_RST;
        end else if (wr_hit && ea == MCU_CTRL_ADDR) begin
            mcu_control_reg <= req.wdata;
        end
    end

    // External SRAM pins
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_addr           <= '0;
            ext_data_o         <= '0;
            ext_data_oe        <= 1'b0;
            ext_strobe_pin_a_n <= 1'b1;
            ext_strobe_pin_b_n <= 1'b1;
        end else if (accept && ext_on) begin
            ext_addr           <= ea;
            ext_data_o         <= req.wdata;
            ext_data_oe        <= req.we;
            ext_strobe_pin_a_n <= !req.we;
            ext_strobe_pin_b_n <= req.we;
        end else if (done) begin
            ext_data_oe        <= 1'b0;
            ext_strobe_pin_a_n <= 1'b1;
            ext_strobe_pin_b_n <= 1'b1;
        end
    end

    // Arming window
    always_ff @(posedge clk) begin
        if (rst) begin
            ee_arm  <= 1'b0;
            arm_cnt <= '0;
        end else if (arm_set) begin
            ee_arm  <= 1'b1;
            arm_cnt <= EE_ARM_CYCLES - 5'h01;
        end else if (ee_arm && arm_cnt == '0) begin
            ee_arm <= 1'b0;
        end else if (ee_arm) begin
            arm_cnt <= arm_cnt - 5'h01;
        end
    end

    // Self-timed write
    always_ff @(posedge clk) begin
        if (rst) begin
            ee_busy <= 1'b0;
            ee_tcnt <= '0;
            wr_addr <= '0;
            wr_data <= '0;
        end else if (ee_wr_go) begin
            ee_busy <= 1'b1;
            ee_tcnt <= EE_TW'(EE_WRITE_LEN - 1);
            wr_addr <= eeprom_address;
            wr_data <= eeprom_data_byte;
        end else if (ee_busy && ee_tcnt == '0) begin
            ee_busy <= 1'b0;
        end else if (ee_busy) begin
            ee_tcnt <= ee_tcnt - 18'h0_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (ee_busy && ee_tcnt == '0) begin
            eemem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            eeprom_address <= '0;
        end else if (wr_hit && !ee_busy) begin
            if (ea == EE_ADRL_ADDR) begin
                eeprom_address[7:0] <= req.wdata;
            end else if (ea == EE_ADRH_ADDR) begin
                eeprom_address[10:8] <= req.wdata[2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            eeprom_data_byte <= '0;
        end else if (ee_rd_go) begin
            eeprom_data_byte <= eemem[eeprom_address];
        end else if (wr_hit && ea == EE_DATA_ADDR) begin
            eeprom_data_byte <= req.wdata;
        end
    end

    // Helper: cycles since the request was taken
    logic [CNT_W-1:0] age;
    logic [CNT_W-1:0] exp_len;
    always_ff @(posedge clk) begin
        if (rst) begin
            age     <= '0;
            exp_len <= '0;
        end else if (accept) begin
            age     <= 5'h01;
            exp_len <= extra + 5'h01;
        end else if (state == ST_BUSY) begin
            age <= age + 5'h01;
        end
    end

    sequence s_int_acc;
        accept && region != RG_EXT && !ee_ctrl_wr;
    endsequence
    property p_int_two;
        s_int_acc |-> ##1 ack;
    endproperty
    a_int_two: assert property (p_int_two)
        else $error("internal access not done in two cycles");

    property p_latency;
        ack |-> age == exp_len;
    endproperty
    a_latency: assert property (p_latency)
        else $error("access latency differs from wait state setting");

    property p_ext_byte0;
        accept && ext_on && !req.stack2 && ws == 2'b00 |-> ##2 ack;
    endproperty
    a_ext_byte0: assert property (p_ext_byte0)
        else $error("external byte access not one cycle longer");

    property p_ext_stack3;
        accept && ext_on && req.stack2 && ws == 2'b11 |-> ##10 ack;
    endproperty
    a_ext_stack3: assert property (p_ext_stack3)
        else $error("external stack access with three waits wrong");

    property p_int_quiet;
        state == ST_BUSY && !lat_ext
            |-> ext_strobe_pin_a_n && ext_strobe_pin_b_n;
    endproperty
    a_int_quiet: assert property (p_int_quiet)
        else $error("strobe active during internal access");

    property p_sre_gate;
        !ext_strobe_pin_a_n || !ext_strobe_pin_b_n
            |-> mcu_control_reg[MC_SRE_BIT];
    endproperty
    a_sre_gate: assert property (p_sre_gate)
        else $error("strobe active with external memory disabled");

    property p_legacy_sram;
        accept && legacy_mode && !req.io_short && ea >= IO_END
            && ea < XIO_END |-> region == RG_SRAM;
    endproperty
    a_legacy_sram: assert property (p_legacy_sram)
        else $error("extended I/O decoded in legacy mode");

    property p_arm_window;
        $rose(ee_arm) ##0 (!arm_set)[*4] |-> ##1 !ee_arm;
    endproperty
    a_arm_window: assert property (p_arm_window)
        else $error("arm bit did not clear after four cycles");

    sequence s_rd_stall;
        ##1 (!ack)[*4] ##1 ack;
    endsequence
    property p_rd_stall;
        ee_rd_go |-> s_rd_stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall)
        else $error("EEPROM read stall not four cycles");

    property p_wr_stall;
        ee_wr_go |-> ##1 (!ack)[*2] ##1 ack;
    endproperty
    a_wr_stall: assert property (p_wr_stall)
        else $error("EEPROM write stall not two cycles");

    property p_no_unarmed;
        $rose(ee_busy) |-> $past(ee_arm);
    endproperty
    a_no_unarmed: assert property (p_no_unarmed)
        else $error("EEPROM write started without arming");

    property p_addr_hold;
        ee_busy ##1 ee_busy |-> $stable(eeprom_address);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("EEPROM address changed during write");
endmodule
`default_nettype wire

// ---- hdl/dma_pkg.sv ----
`default_nettype none
package dma_pkg;
    localparam int PC_W = 15;
    localparam int DA_W = 16;
    localparam int SRAM_DEPTH = 4096;
    localparam int SRAM_AW = 12;
    localparam int EE_DEPTH = 2048;
    localparam int EE_AW = 11;
    localparam int EE_TW = 18;
    localparam int CNT_W = 5;

    // Data space boundaries
    localparam logic [15:0] RF_END     = 16'h0020;
    localparam logic [15:0] IO_END     = 16'h0060;
    localparam logic [15:0] XIO_END    = 16'h0100;
    localparam logic [15:0] SRAM_END_N = 16'h1100;
    localparam logic [15:0] SRAM_END_L = 16'h1000;
    localparam logic [15:0] IO_BASE    = 16'h0020;

    // Own registers in the standard I/O space (data addresses)
    localparam logic [15:0] EE_CTRL_ADDR = 16'h003C;
    localparam logic [15:0] EE_DATA_ADDR = 16'h003D;
    localparam logic [15:0] EE_ADRL_ADDR = 16'h003E;
    localparam logic [15:0] EE_ADRH_ADDR = 16'h003F;
    localparam logic [15:0] MCU_CTRL_ADDR = 16'h0055;

    localparam int EC_RE_BIT  = 0;
    localparam int EC_WE_BIT  = 1;
    localparam int EC_ARM_BIT = 2;
    localparam int MC_SRE_BIT = 7;
    localparam int MC_WS_LSB  = 2;
    localparam logic [7:0] MCU_CTRL_RST = 8'h00;
    localparam logic [7:0] EXT_UNDEF    = 8'hFF;

    localparam logic [CNT_W-1:0] EE_ARM_CYCLES   = 5'h04;
    localparam logic [CNT_W-1:0] EE_RD_STALL     = 5'h04;
    localparam logic [CNT_W-1:0] EE_WR_STALL     = 5'h02;
    localparam logic [CNT_W-1:0] EXT_BYTE_EXTRA  = 5'h01;
    localparam logic [CNT_W-1:0] EXT_STACK_EXTRA = 5'h03;

    localparam int CLK_PERIOD_NS    = 40;
    localparam int EE_WRITE_TIME_NS = 8_400_000;
    localparam int EE_WRITE_CYCLES  = EE_WRITE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        RG_RF   = 3'b000,
        RG_IO   = 3'b001,
        RG_XIO  = 3'b010,
        RG_SRAM = 3'b011,
        RG_EXT  = 3'b100
    } dma_region_t;

    typedef enum logic [1:0] {
        PM_DIRECT  = 2'b00,
        PM_DISP    = 2'b01,
        PM_PREDEC  = 2'b10,
        PM_POSTINC = 2'b11
    } dma_ptr_mode_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } dma_state_t;

    typedef struct packed {
        logic [15:0]   addr;
        logic [5:0]    disp;
        dma_ptr_mode_t mode;
        logic          we;
        logic          io_short;
        logic          stack2;
        logic [7:0]    wdata;
    } dma_req_t;

    function automatic dma_region_t dma_decode(input logic [15:0] a,
                                               input logic legacy);
        if (a < RF_END)
            return RG_RF;
        if (a < IO_END)
            return RG_IO;
        if (legacy)
            return (a < SRAM_END_L) ? RG_SRAM : RG_EXT;
        if (a < XIO_END)
            return RG_XIO;
        return (a < SRAM_END_N) ? RG_SRAM : RG_EXT;
    endfunction
endpackage
`default_nettype wire

// ---- test/dma_ext_sram.sv ----
`default_nettype none
module dma_ext_sram (
    input  wire logic        clk,
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_data_o,
    input  wire logic        ext_data_oe,
    input  wire logic        ext_strobe_pin_a_n,
    input  wire logic        ext_strobe_pin_b_n,
    output var  logic [7:0]  ext_data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    // Byte stored while the write strobe is low
    always_ff @(posedge clk) begin
        if (!ext_strobe_pin_a_n && ext_data_oe)
            mem[ext_addr] <= ext_data_o;
        if (!ext_strobe_pin_b_n)
            last <= mem[ext_addr];
    end
    // Released bus shows the inverse of the last byte
    assign ext_data_i = ext_strobe_pin_b_n ? ~last : mem[ext_addr];
endmodule
`default_nettype wire

// ---- test/data_memory_eeprom_access_tb.sv ----
`default_nettype none
module data_memory_eeprom_access_tb;
    import dma_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WLEN = 30;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            legacy_mode = 1'b0;
    logic [PC_W-1:0] pc_next = '0;
    logic            req_valid = 1'b0;
    dma_req_t        req = '0;
    logic [7:0]      periph_rdata = 8'h00;
    logic [PC_W-1:0] prog_addr;
    logic            req_ready, ack, ext_data_oe, ext_a_n, ext_b_n;
    logic [7:0]      rdata, ext_data_o, ext_data_i, last_rd;
    logic [15:0]     ptr_upd, ext_addr, last_ptr;
    logic [31:0]     seed = 32'h3257_e359;
    int              err_total = 0;
    int              checks = 0;
    int              scnt = 0;
    int              last_lat;

    always #20 clk = ~clk;
    always @(negedge clk)
        if (ext_a_n !== 1'b1 || ext_b_n !== 1'b1)
            scnt++;

    dma_access #(.EE_WRITE_LEN(WLEN)) dma_access_inst (
        .clk(clk), .rst(rst), .legacy_mode(legacy_mode),
        .pc_next(pc_next), .prog_addr(prog_addr), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .ack(ack), .rdata(rdata),
        .ptr_upd(ptr_upd), .periph_rdata(periph_rdata),
        .ext_addr(ext_addr), .ext_data_o(ext_data_o),
        .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i),
        .ext_strobe_pin_a_n(ext_a_n), .ext_strobe_pin_b_n(ext_b_n));
    dma_ext_sram dma_ext_sram_inst (
        .clk(clk), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
        .ext_data_oe(ext_data_oe), .ext_strobe_pin_a_n(ext_a_n),
        .ext_strobe_pin_b_n(ext_b_n), .ext_data_i(ext_data_i));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function int ext_lat(input int ws, input logic s2);
        return s2 ? 4 + 2 * ws : 2 + ws;
    endfunction

    task chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_int(input string n, input int e, input int g);
        checks++;
        if (g != e) begin
            err_total++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task acc(input logic [15:0] a, input logic w, input logic [7:0] d,
             input dma_ptr_mode_t m, input logic [5:0] ds, input logic io,
             input logic s2);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{a, ds, m, w, io, s2, d};
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        req_valid <= 1'b0;
        last_lat = 0;
        do begin
            @(negedge clk);
            last_lat++;
        end while (ack !== 1'b1 && last_lat < 200);
        last_rd = rdata;
        last_ptr = ptr_upd;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        acc(a, 1'b1, d, PM_DIRECT, 6'h00, 1'b0, 1'b0);
    endtask
    task rd(input logic [15:0] a);
        acc(a, 1'b0, 8'h00, PM_DIRECT, 6'h00, 1'b0, 1'b0);
    endtask
    task rdc(input logic [15:0] a, input logic [7:0] e, input int l);
        rd(a);
        chk_val("rdata", {8'h00, e}, {8'h00, last_rd});
        chk_int("latency", l, last_lat);
    endtask

    initial begin
        logic [31:0] r;
        logic [15:0] a;
        logic [7:0]  ee_d [2];
        int          s;
        int          n;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_val("idle outputs", 16'h0007,
                {11'h0, ack, ext_data_oe, ext_a_n, ext_b_n, req_ready});
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            @(posedge clk);
            pc_next <= r[PC_W-1:0];
            @(posedge clk);
            @(negedge clk);
            chk_val("prog_addr", {1'b0, r[14:0]}, {1'b0, prog_addr});
        end
        $display("test program address done");
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            legacy_mode <= m[0];
            s = scnt;
            for (int i = 0; i < 6; i++) begin
                r = rnd();
                a = m ? 16'h0060 + r[15:0] % 16'h0FA0 : 16'h0100 + r[11:0];
                wr(a, r[23:16]);
                rdc(a, r[23:16], 1);
            end
            rdc(m ? SRAM_END_L : SRAM_END_N, EXT_UNDEF, 1);
            chk_int("strobe cycles", s, scnt);
        end
        wr(16'h0080, 8'h5A);
        rdc(16'h0080, 8'h5A, 1);
        r = rnd();
        @(posedge clk);
        legacy_mode <= 1'b0;
        periph_rdata <= r[7:0];
        rdc(16'h0080, r[7:0], 1);
        $display("test internal map done");
        a = 16'h0200 + r[25:16];
        wr(a + 16'd63, 8'hC3);
        acc(a, 1'b0, 8'h00, PM_DISP, 6'h3F, 1'b0, 1'b0);
        chk_val("disp rdata", 16'h00C3, {8'h00, last_rd});
        wr(a - 16'd1, 8'h3C);
        acc(a, 1'b0, 8'h00, PM_PREDEC, 6'h00, 1'b0, 1'b0);
        chk_val("predec rdata", 16'h003C, {8'h00, last_rd});
        chk_val("ptr_upd", a - 16'd1, last_ptr);
        acc(a, 1'b1, 8'h11, PM_POSTINC, 6'h00, 1'b0, 1'b0);
        chk_val("ptr_upd", a + 16'd1, last_ptr);
        $display("test pointer modes done");
        for (int ws = 0; ws < 4; ws++) begin
            wr(MCU_CTRL_ADDR, {1'b1, 3'b000, ws[1:0], 2'b00});
            r = rnd();
            a = SRAM_END_N + r[15:0] % 16'hEF00;
            s = scnt;
            wr(a, r[23:16]);
            chk_int("ext write latency", ext_lat(ws, 0), last_lat);
            rdc(a, r[23:16], ext_lat(ws, 0));
            acc(a, 1'b1, r[31:24], PM_DIRECT, 6'h00, 1'b0, 1'b1);
            chk_int("stack latency", ext_lat(ws, 1), last_lat);
            chk_int("ext strobes", 1, int'(scnt > s));
        end
        @(posedge clk);
        legacy_mode <= 1'b1;
        wr(SRAM_END_L, 8'h77);
        rdc(SRAM_END_L, 8'h77, ext_lat(3, 0));
        @(posedge clk);
        legacy_mode <= 1'b0;
        $display("test external memory done");
        wr(EE_ADRH_ADDR, 8'hFF);
        rdc(EE_ADRH_ADDR, 8'h07, 1);
        for (int i = 0; i < 2; i++) begin
            r = rnd();
            a = i ? 16'h07FF : 16'h0000;
            ee_d[i] = r[7:0];
            wr(EE_ADRH_ADDR, a[15:8]);
            wr(EE_ADRL_ADDR, a[7:0]);
            wr(EE_DATA_ADDR, ee_d[i]);
            wr(EE_CTRL_ADDR, 8'h04);
            wr(EE_CTRL_ADDR, 8'h02);
            chk_int("write stall", 3, last_lat);
            rd(EE_CTRL_ADDR);
            chk_val("busy", 16'h0002, {14'h0, last_rd[1], 1'b0});
            wr(EE_ADRL_ADDR, ~a[7:0]);
            rdc(EE_ADRL_ADDR, a[7:0], 1);
            wr(EE_CTRL_ADDR, 8'h01);
            chk_int("blocked read stall", 1, last_lat);
            n = 0;
            do begin
                rd(EE_CTRL_ADDR);
                n++;
            end while (last_rd[1] !== 1'b0 && n < 40);
            chk_val("busy end", 16'h0000, {15'h0, last_rd[1]});
        end
        for (int i = 0; i < 2; i++) begin
            wr(EE_ADRH_ADDR, i ? 8'h07 : 8'h00);
            wr(EE_ADRL_ADDR, i ? 8'hFF : 8'h00);
            wr(EE_CTRL_ADDR, 8'h01);
            chk_int("read stall", 5, last_lat);
            acc(16'h001D, 1'b0, 8'h00, PM_DIRECT, 6'h00, 1'b1, 1'b0);
            chk_val("ee byte", {8'h00, ee_d[i]}, {8'h00, last_rd});
        end
        wr(EE_CTRL_ADDR, 8'h02);
        chk_int("unarmed strobe", 1, last_lat);
        wr(EE_CTRL_ADDR, 8'h04);
        repeat (6) @(posedge clk);
        wr(EE_CTRL_ADDR, 8'h02);
        chk_int("late strobe", 1, last_lat);
        rd(EE_CTRL_ADDR);
        chk_val("ctrl", 16'h0000, {13'h0, last_rd[2:0]});
        $display("test eeprom done");
        final_report;
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        final_report;
    end
endmodule
`default_nettype wire
